// >>> test_voltage_sensor_fabric_access.sv
// Self-checking bench: controller and sensor joined over the link
`timescale 1ns/1ps
`include "vsa_consts.svh"
module test_voltage_sensor_fabric_access
   import vsa_pkg::*;
();
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [31:0] dat   = 32'h0;
   logic [31:0] dat_o, rdat, st;
   logic        ack, irq, cal;
   logic [5:0]  smp [16];
   logic [5:0]  v;
   logic [7:0]  shw = 8'h00;
   int          errors = 0;
   int          n_tests = 0;
   int          lo, hi;
   realtime     t_last = 0;
   vsa_link_if link ();
   vsa_ctrl vsa_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .irq_o(irq), .lnk(link));
   vsa_sensor vsa_sensor_inst (.lnk(link), .sample_i(smp));
   vsa_link_properties vsa_link_properties_inst (.sens_clk(link.sens_clk),
      .sens_rst(link.sens_rst), .access_en(link.access_en), .cfg_strobe(link.cfg_strobe),
      .cfg_data(link.cfg_data), .chan_sel(link.chan_sel), .conv_done(link.conv_done),
      .seq_done(link.seq_done), .result(link.result));
   always #4 clk_i = ~clk_i;
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task give_verdict();
      $display("errors %0d tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Link clock period and serial word as seen on the wire
   always @(posedge link.sens_clk) begin
      if (t_last > 0) check(32'(($realtime - t_last) >= 90.9), 32'h1);
      t_last = $realtime;
      if (link.cfg_strobe) shw <= {link.cfg_data, shw[7:1]};
   end
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      i = 0;
      do begin @(posedge clk_i); i++; end while (ack !== 1'b1 && i < 50);
      if (ack !== 1'b1) begin errors++; give_verdict(); end
      rdat = dat_o;
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge clk_i);
   endtask
   // Extra cycles at the end: the line lags the status clear by one
   task automatic take();
      int i;
      for (i = 0; i < 1000 && irq !== 1'b1; i++) @(posedge clk_i);
      if (irq !== 1'b1) begin errors++; give_verdict(); end
      wb(0, `VSA_REG_STAT, 0);
      check(rdat[0], 1);
      wb(0, `VSA_REG_RESULT, 0);
      v = rdat[5:0];
      wb(0, `VSA_REG_IRQ, 0);
      st = rdat;
      wb(1, `VSA_REG_IRQ, 32'h3);
      repeat (2) @(posedge clk_i);
      check(irq, 0);
   endtask
   initial begin
      for (int k = 0; k < 16; k++) smp[k] = 6'(4 * k + 1);
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check(link.sens_rst, 1);
      check(link.access_en, 0);
      wb(0, `VSA_REG_RESULT, 0);
      check(rdat, 0);
      wb(0, 8'h1C, 0);
      check(rdat, 0);
      wb(1, `VSA_REG_MASK, 0);
      wb(1, `VSA_REG_CFG, 8'h02);
      wb(1, `VSA_REG_CTRL, 1);
      rdat = 0;
      for (int i = 0; i < 400 && rdat[0] !== 1'b1; i++) wb(0, `VSA_REG_IRQ, 0);
      check(rdat[0], 1);
      check(irq, 0);
      wb(1, `VSA_REG_MASK, 1);
      repeat (2) @(posedge clk_i);
      check(irq, 1);
      for (int m = 0; m < 3; m++) begin
         cal = (m != 1);
         lo = (m == 0) ? 2 : 0;
         hi = (m == 2) ? 1 : 7;
         wb(1, `VSA_REG_CTRL, 0);
         wb(1, `VSA_REG_CFG, {1'b1, cal, 4'hF, 2'(m)});
         wb(0, `VSA_REG_CFG, 0);
         check(rdat, {1'b0, cal, 4'h0, 2'(m)});
         wb(1, `VSA_REG_IRQ, 32'h3);
         wb(0, `VSA_REG_RESULT, 0);
         wb(1, `VSA_REG_CTRL, 1);
         for (int ch = lo; ch <= hi; ch++) begin
            take();
            check(v, 6'(smp[ch] + cal));
            check(st[1], ch == hi);
         end
         check(shw, {1'b0, cal, 4'h0, 2'(m)});
      end
      // Channel picked by the controller, then changed mid-run
      wb(1, `VSA_REG_CTRL, 0);
      wb(1, `VSA_REG_CHAN, 9);
      wb(1, `VSA_REG_CFG, 8'h03);
      wb(1, `VSA_REG_IRQ, 32'h3);
      wb(1, `VSA_REG_CTRL, 1);
      take();
      check(v, smp[9]);
      check(link.chan_sel, 9);
      wb(1, `VSA_REG_CHAN, 12);
      repeat (3) take();
      check(v, smp[12]);
      wb(1, `VSA_REG_CTRL, 0);
      repeat (30) @(posedge clk_i);
      check(link.sens_rst, 1);
      check(link.access_en, 0);
      give_verdict();
   end
endmodule

// >>> vsa_consts.svh
// Constants for the voltage sensor fabric access block
`ifndef VSA_CONSTS_SVH
`define VSA_CONSTS_SVH
`define VSA_CFG_W        8
`define VSA_CFG_RESET    8'h00
`define VSA_MODE_LSB     0
`define VSA_MODE_MSB     1
`define VSA_CAL_BIT      6
`define VSA_CFG_ZERO_MASK 8'hBC
`define VSA_CHAN_W       4
`define VSA_RES_LSB      6
`define VSA_CONV_CYCLES  16
`define VSA_SETUP_WAIT   2
`define VSA_SENS_FMAX_KHZ 11000
`define VSA_CLK_KHZ       125000
`define VSA_SENS_DIV ((`VSA_CLK_KHZ + `VSA_SENS_FMAX_KHZ - 1) / `VSA_SENS_FMAX_KHZ)
`define VSA_REG_CTRL     8'h00
`define VSA_REG_CFG      8'h04
`define VSA_REG_CHAN     8'h08
`define VSA_REG_STAT     8'h0C
`define VSA_REG_RESULT   8'h10
`define VSA_REG_IRQ      8'h14
`define VSA_REG_MASK     8'h18
`define VSA_IRQ_EOC      0
`define VSA_IRQ_EOS      1
`endif

// >>> vsa_ctrl.sv
// Controller end: Wishbone registers, sensor clock, setup sequence, result capture
`timescale 1ns/1ps
`include "vsa_consts.svh"
module vsa_ctrl
   import vsa_pkg::*;
#(
   parameter int DIV = `VSA_SENS_DIV
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             irq_o,
   vsa_link_if.ctrl         lnk
);
   logic [7:0]  cfg;
   logic [3:0]  chan;
   logic        go;
   logic        go_pulse;
   logic [1:0]  irq_stat;
   logic [1:0]  irq_mask;
   logic [5:0]  result;
   logic        res_new;
   logic [7:0]  div_cnt;
   logic        sclk;
   logic        fall;
   logic [3:0]  step;
   vsa_ctl_e    state;
   logic        eoc_s1;
   logic        eoc_s2;
   logic        eoc_s3;
   logic        eos_s1;
   logic        eos_s2;
   logic        eos_s3;
   logic [5:0]  res_s1;
   logic [5:0]  res_s2;
   logic        en;
   logic        srst;
   logic        strobe;
   logic        sdata;
   logic [3:0]  chsel;
   logic        wr;
   logic        rd;
   logic        eoc_fall;
   logic        eos_rise;

   assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
   assign rd = cyc_i && stb_i && !ack_o;

   // One-cycle ack; unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         ack_o <= rd;
         dat_o <= 32'h0;
         if (rd && !we_i) begin
            case (adr_i)
               `VSA_REG_CTRL:   dat_o <= {31'h0, go};
               `VSA_REG_CFG:    dat_o <= {24'h0, cfg};
               `VSA_REG_CHAN:   dat_o <= {28'h0, chan};
               `VSA_REG_STAT:   dat_o <= {25'h0, state, 3'h0, res_new};
               `VSA_REG_RESULT: dat_o <= {26'h0, result};
               `VSA_REG_IRQ:    dat_o <= {30'h0, irq_stat};
               `VSA_REG_MASK:   dat_o <= {30'h0, irq_mask};
               default:         dat_o <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg      <= `VSA_CFG_RESET;
         chan     <= 4'h0;
         go       <= 1'b0;
         irq_mask <= 2'b00;
      end else if (wr) begin
         case (adr_i)
            // Channel and reserved bits forced low whatever software writes
            `VSA_REG_CFG:  cfg      <= dat_i[7:0] & ~`VSA_CFG_ZERO_MASK;
            `VSA_REG_CHAN: chan     <= dat_i[3:0];
            `VSA_REG_CTRL: go       <= dat_i[0];
            `VSA_REG_MASK: irq_mask <= dat_i[1:0];
            default: ;
         endcase
      end
   end
   assign go_pulse = wr && (adr_i == `VSA_REG_CTRL) && dat_i[0];

   // Sensor clock divided down to stay under its ceiling
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt <= 8'h00;
         sclk    <= 1'b0;
      end else if (div_cnt == 8'(DIV / 2 + DIV % 2 - 1)) begin
         div_cnt <= 8'h00;
         sclk    <= ~sclk;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end
   // Setup link outputs change on sensor clock falls so the sensor sees stable levels; clearing go drops them on any edge
   assign fall = (div_cnt == 8'(DIV / 2 + DIV % 2 - 1)) && sclk;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state  <= VSA_IDLE;
         step   <= 4'h0;
         en     <= 1'b0;
         srst   <= 1'b1;
         strobe <= 1'b0;
         sdata  <= 1'b0;
         chsel  <= 4'h0;
      end else if (go_pulse) begin
         // Ahead of the go test: go still reads 0 on the edge that sets it
         state  <= VSA_ENABLE;
         step   <= 4'h0;
         srst   <= 1'b1;
         strobe <= 1'b0;
      end else if (!go) begin
         state  <= VSA_IDLE;
         en     <= 1'b0;
         srst   <= 1'b1;
         strobe <= 1'b0;
      end else if (fall) begin
         chsel <= chan;
         case (state)
            VSA_ENABLE: begin
               en   <= 1'b1;
               step <= step + 4'h1;
               if (step == 4'(`VSA_SETUP_WAIT)) begin
                  srst  <= 1'b0;
                  step  <= 4'h0;
                  state <= VSA_UNRST;
               end
            end
            VSA_UNRST: begin
               step <= step + 4'h1;
               if (step == 4'(`VSA_SETUP_WAIT)) begin
                  step  <= 4'h0;
                  state <= VSA_SHIFT;
               end
            end
            VSA_SHIFT: begin
               if (step == 4'(`VSA_CFG_W)) begin
                  strobe <= 1'b0;
                  state  <= VSA_RUN;
               end else begin
                  strobe <= 1'b1;
                  sdata  <= cfg[step[2:0]];
                  step   <= step + 4'h1;
               end
            end
            VSA_RUN: ;
            default: state <= VSA_IDLE;
         endcase
      end
   end

   // Sensor outputs are another domain's timing: two flops first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         eoc_s1 <= 1'b0;
         eoc_s2 <= 1'b0;
         eoc_s3 <= 1'b0;
         eos_s1 <= 1'b0;
         eos_s2 <= 1'b0;
         eos_s3 <= 1'b0;
         res_s1 <= 6'h00;
         res_s2 <= 6'h00;
      end else begin
         eoc_s1 <= lnk.conv_done;
         eoc_s2 <= eoc_s1;
         eoc_s3 <= eoc_s2;
         eos_s1 <= lnk.seq_done;
         eos_s2 <= eos_s1;
         eos_s3 <= eos_s2;
         res_s1 <= lnk.result[11:`VSA_RES_LSB];
         res_s2 <= res_s1;
      end
   end
   assign eoc_fall = eoc_s3 && !eoc_s2;
   assign eos_rise = eos_s2 && !eos_s3;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result   <= 6'h00;
         res_new  <= 1'b0;
         irq_stat <= 2'b00;
      end else begin
         if (eoc_fall) begin
            result <= res_s2;
         end
         // New events win over a same-cycle clear
         res_new  <= eoc_fall || (res_new && !(rd && !we_i && adr_i == `VSA_REG_RESULT));
         irq_stat <= (irq_stat & ~((wr && adr_i == `VSA_REG_IRQ) ? dat_i[1:0] : 2'b00))
                     | {eos_rise, eoc_fall};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   assign lnk.sens_clk   = sclk;
   assign lnk.sens_rst   = srst;
   assign lnk.access_en  = en;
   assign lnk.cfg_strobe = strobe;
   assign lnk.cfg_data   = sdata;
   assign lnk.chan_sel   = chsel;
endmodule

// >>> vsa_link_if.sv
// Fabric link between sensor and controller
`timescale 1ns/1ps
interface vsa_link_if;
   logic        sens_clk;
   logic        sens_rst;
   logic        access_en;
   logic        cfg_strobe;
   logic        cfg_data;
   logic [3:0]  chan_sel;
   logic        conv_done;
   logic        seq_done;
   logic [11:0] result;
   modport sensor (input sens_clk, sens_rst, access_en, cfg_strobe, cfg_data, chan_sel,
                   output conv_done, seq_done, result);
   modport ctrl   (output sens_clk, sens_rst, access_en, cfg_strobe, cfg_data, chan_sel,
                   input conv_done, seq_done, result);
endinterface

// >>> vsa_link_properties.sv
// Assertions on the sensor link between controller and sensor
`timescale 1ns/1ps
module vsa_link_properties (
   input  wire logic        sens_clk,
   input  wire logic        sens_rst,
   input  wire logic        access_en,
   input  wire logic        cfg_strobe,
   input  wire logic        cfg_data,
   input  wire logic [3:0]  chan_sel,
   input  wire logic        conv_done,
   input  wire logic        seq_done,
   input  wire logic [11:0] result
);
   logic [7:0] cfg;
   logic [3:0] cnt;
   logic [3:0] len;
   default clocking @(posedge sens_clk); endclocking
   default disable iff (sens_rst);
   always_comb len = (cfg[1:0] == 2'b00) ? 4'h6 : (cfg[1:0] == 2'b01) ? 4'h8 : 4'h2;
   // Shadow of the shifted word, first bit lands in bit 0
   always_ff @(posedge sens_clk or posedge sens_rst) begin
      if (sens_rst) cfg <= 8'h00;
      else if (cfg_strobe) cfg <= {cfg_data, cfg[7:1]};
   end
   // Conversions seen since the last end of sequence
   always_ff @(posedge sens_clk or posedge sens_rst) begin
      if (sens_rst) cnt <= 4'h0;
      else if (cfg_strobe) cnt <= 4'h0;
      else if (conv_done) cnt <= seq_done ? 4'h0 : cnt + 4'h1;
   end
   seq_with_conv_a: assert property (seq_done |-> conv_done)
      else $error("sequence end without conversion end");
   seq_pulse_a: assert property (seq_done |=> !seq_done)
      else $error("sequence end longer than one cycle");
   conv_pulse_a: assert property (conv_done |=> !conv_done)
      else $error("conversion end longer than one cycle");
   result_low_a: assert property (conv_done |-> result[5:0] == 6'h00)
      else $error("reserved result bits not zero");
   release_quiet_a: assert property ($fell(sens_rst) |-> !conv_done [*8])
      else $error("conversion right after reset release");
   enable_first_a: assert property ($fell(sens_rst) |-> access_en && $past(access_en, 2))
      else $error("reset released too soon after enable");
   config_gap_a: assert property ($rose(cfg_strobe) |-> $past(sens_rst, 2) == 1'b0)
      else $error("strobe too soon after reset release");
   strobe_len_a: assert property ($rose(cfg_strobe) |-> cfg_strobe [*8] ##1 !cfg_strobe)
      else $error("strobe not eight cycles");
   no_conv_cfg_a: assert property (cfg_strobe |-> !conv_done)
      else $error("conversion end while shifting");
   conv_start_a: assert property ($fell(cfg_strobe) |-> ##[1:40] conv_done)
      else $error("no conversion after strobe drop");
   seq_length_a: assert property (seq_done && cfg[1:0] != 2'b11 |-> cnt == len - 4'h1)
      else $error("wrong sequence length");
endmodule

// >>> vsa_pkg.sv
// Types for the voltage sensor fabric access block
package vsa_pkg;
   typedef enum logic [1:0] {
      VSA_SEQ_2_7  = 2'b00,
      VSA_SEQ_0_7  = 2'b01,
      VSA_SEQ_0_1  = 2'b10,
      VSA_SEQ_CORE = 2'b11
   } vsa_mode_e;
   typedef enum logic [2:0] {
      VSA_IDLE   = 3'b000,
      VSA_ENABLE = 3'b001,
      VSA_UNRST  = 3'b010,
      VSA_SHIFT  = 3'b011,
      VSA_RUN    = 3'b100
   } vsa_ctl_e;
endpackage

// >>> vsa_sensor.sv
// Voltage sensor end: configuration shift, sequencer, conversion model
`timescale 1ns/1ps
`include "vsa_consts.svh"
module vsa_sensor
   import vsa_pkg::*;
#(
   parameter int CONV_CYCLES = `VSA_CONV_CYCLES
) (
   vsa_link_if.sensor   lnk,
   input  wire logic [5:0] sample_i [16]
);
   logic [7:0] cfg;
   logic [3:0] chan;
   logic [3:0] last;
   logic [3:0] first;
   logic [7:0] cnt;
   logic       running;
   logic       strobe_q;
   logic       eoc;
   logic       eos;
   logic [5:0] res;
   vsa_mode_e  mode;

   assign mode  = vsa_mode_e'(cfg[`VSA_MODE_MSB:`VSA_MODE_LSB]);
   always_comb begin
      case (mode)
         VSA_SEQ_2_7: begin
            first = 4'h2;
            last  = 4'h7;
         end
         VSA_SEQ_0_7: begin
            first = 4'h0;
            last  = 4'h7;
         end
         VSA_SEQ_0_1: begin
            first = 4'h0;
            last  = 4'h1;
         end
         default: begin
            first = lnk.chan_sel;
            last  = lnk.chan_sel;
         end
      endcase
   end

   // Everything clears under reset; conversions only while access is enabled
   always_ff @(posedge lnk.sens_clk or posedge lnk.sens_rst) begin
      if (lnk.sens_rst) begin
         cfg      <= `VSA_CFG_RESET;
         strobe_q <= 1'b0;
         running  <= 1'b0;
         chan     <= 4'h0;
         cnt      <= 8'h00;
         eoc      <= 1'b0;
         eos      <= 1'b0;
         res      <= 6'h00;
      end else if (!lnk.access_en) begin
         strobe_q <= 1'b0;
         running  <= 1'b0;
         eoc      <= 1'b0;
         eos      <= 1'b0;
      end else begin
         strobe_q <= lnk.cfg_strobe;
         eoc      <= 1'b0;
         eos      <= 1'b0;
         if (lnk.cfg_strobe) begin
            cfg     <= {lnk.cfg_data, cfg[7:1]};
            running <= 1'b0;
            cnt     <= 8'h00;
         end else if (strobe_q) begin
            running <= 1'b1;
            chan    <= first;
            cnt     <= 8'h00;
         end else if (running) begin
            if (cnt == 8'(CONV_CYCLES - 1)) begin
               cnt <= 8'h00;
               eoc <= 1'b1;
               // Calibration simply offsets the raw sample by one code
               res <= cfg[`VSA_CAL_BIT] ? sample_i[chan] + 6'h01 : sample_i[chan];
               if (chan == last) begin
                  eos  <= 1'b1;
                  chan <= first;
               end else begin
                  chan <= (mode == VSA_SEQ_CORE) ? lnk.chan_sel : chan + 4'h1;
               end
            end else begin
               cnt <= cnt + 8'h01;
            end
         end
      end
   end

   assign lnk.conv_done = eoc;
   assign lnk.seq_done  = eos;
   assign lnk.result    = {res, 6'h00};
endmodule
